// [exvag_regs.svh]
`ifndef EXVAG_REGS_SVH
`define EXVAG_REGS_SVH

// Register byte offsets on the AXI4-Lite port.
`define EXVAG_OFS_RESET_BASE 8'h00
`define EXVAG_OFS_HOST_BASE  8'h04
`define EXVAG_OFS_GUEST_BASE 8'h08
`define EXVAG_OFS_CONFIG     8'h0C
`define EXVAG_OFS_LAST_ADDR  8'h10

// Fields of the three base registers.
`define EXVAG_BASE_MASK      32'hFFFF_FE00
`define EXVAG_BASE_INTR_OFFSET_REDUCE_BIT_BIT  0
`define EXVAG_BASE_DV_BIT    1
`define EXVAG_BASE_WMASK     32'hFFFF_FE03

// Fields of the configuration register.
`define EXVAG_CFG_SYSTEM_ERROR_EXC_GUEST  0
`define EXVAG_CFG_MEMPROT_GUEST 1
`define EXVAG_CFG_TABLE_EN      2

// Reset values.
`define EXVAG_RST_BASE   32'h0000_0000
`define EXVAG_RST_CONFIG 3'h0

// Offsets of the vector table.
`define EXVAG_OFF_RESET    9'h000
`define EXVAG_OFF_UINT     9'h100
`define EXVAG_OFF_UINT_MIN 9'h1F0
`define EXVAG_PRIO_LAST    8'h0F

// AXI responses and timing.
`define EXVAG_RESP_OKAY   2'h0
`define EXVAG_RESP_SLVERR 2'h2
`define EXVAG_VEC_LATENCY 1

`endif

// [exvag_pkg.sv]
package exvag_pkg;

    // Cause codes in vector order: code times 16 is the fixed offset.
    typedef enum logic [4:0] {
        CAUSE_RESET,
        CAUSE_SYSTEM_ERROR_EXC,
        CAUSE_HV_TRAP,
        CAUSE_FE_TRAP,
        CAUSE_SW_TRAP_A,
        CAUSE_SW_TRAP_B,
        CAUSE_RESV_INSTR,
        CAUSE_FPU,
        CAUSE_COPROC,
        CAUSE_MEM_PROTECT,
        CAUSE_PRIVILEGE,
        CAUSE_SPARE,
        CAUSE_MISALIGN,
        CAUSE_BACKGROUND,
        CAUSE_NONMASKABLE,
        CAUSE_FE_INTR,
        CAUSE_USER_INTR
    } exvag_cause_e;

    // One acknowledged exception, with status bits as updated by the acknowledge.
    typedef struct packed {
        exvag_cause_e cause;
        logic [7:0]   priority_level;
        logic         guest_mode_flag;
        logic         base_select_bit;
    } exvag_req_s;

    // Whole state of the block.
    typedef struct packed {
        logic [31:0] reset_base_reg;
        logic [31:0] host_exc_base_reg;
        logic [31:0] guest_exc_base_reg;
        logic [2:0]  guest_routing_config;
        logic [31:0] vec_addr;
        logic        vec_valid;
        logic        vec_table;
        logic        aw_got;
        logic [31:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } exvag_state_s;

endpackage

// [exvag_vector_gen.sv]
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "exvag_regs.svh"
// Overview of operation
// - Resets and host-mode exceptions always vector as base register plus cause offset.
// - User interrupts may choose direct vectoring or a handler table held in memory.
// - Host-mode exception with base select one uses the host exception base.
// - Host-mode exception with base select zero uses the reset base.
// - Guest-mode exceptions treat base select as one and use the guest base.
// - Reset uses the reset base regardless of select bits, offset zero.
// - Handler address is selected base plus the offset for the cause.
// - Reduction bit of the selected base set gives every user interrupt offset 0x100.
// - Base and offset choice use status words as updated by the acknowledge.
// - Other causes take fixed offsets 0x000 to 0x0F0 in steps of 0x10.
// - Reduction bit clear, user interrupt priority 0 uses offset 0x100.
// - Reduction bit clear, priority 1 to 14 uses 0x100 plus sixteen times priority.
// - Reduction bit clear, priority 15 or lower uses offset 0x1F0.
// - Reset, hypervisor trap, background and nonmaskable never use the guest base.
// - System error and memory protection use the guest base only when routed there.
module exvag_vector_gen (
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Acknowledged exception from the acknowledge logic.
    input  wire logic                  req_valid,
    input  wire exvag_pkg::exvag_req_s req,
    // Handler address to the fetch logic.
    output logic                       vec_valid,
    output logic [31:0]                vec_addr,
    output logic                       vec_table,
    // AXI4-Lite write address and data.
    input  wire logic [31:0]           awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // AXI4-Lite write response.
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read.
    input  wire logic [31:0]           araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready
);

    exvag_pkg::exvag_state_s st_ff;
    exvag_pkg::exvag_state_s nxt_st;
    logic                    is_uint;
    logic                    guest_ok;
    logic                    use_guest;
    logic [31:0]             sel_base;
    logic                    sel_intr_offset_reduce_bit;
    logic [8:0]              sel_off;
    logic [31:0]             new_addr;

    // Register index from a byte address; 3'h7 marks an unmapped address.
    function automatic logic [2:0] reg_index(input logic [31:0] a);
        case (a)
            {24'h0, `EXVAG_OFS_RESET_BASE}: reg_index = 3'h0;
            {24'h0, `EXVAG_OFS_HOST_BASE}:  reg_index = 3'h1;
            {24'h0, `EXVAG_OFS_GUEST_BASE}: reg_index = 3'h2;
            {24'h0, `EXVAG_OFS_CONFIG}:     reg_index = 3'h3;
            {24'h0, `EXVAG_OFS_LAST_ADDR}:  reg_index = 3'h4;
            default:                        reg_index = 3'h7;
        endcase
    endfunction

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = res;
    endfunction

    // Offset lookup on cause and priority; kept combinational to feed the adder directly.
    function automatic logic [8:0] cause_offset(input exvag_pkg::exvag_cause_e c,
                                                input logic [7:0] prio, input logic intr_offset_reduce_bit);
        if (c == exvag_pkg::CAUSE_RESET)
        begin
            cause_offset = `EXVAG_OFF_RESET;
        end
        else if (c != exvag_pkg::CAUSE_USER_INTR)
        begin
            cause_offset = {1'b0, c[3:0], 4'h0};
        end
        else if (intr_offset_reduce_bit || prio == 8'h00)
        begin
            cause_offset = `EXVAG_OFF_UINT;
        end
        else if (prio < `EXVAG_PRIO_LAST)
        begin
            cause_offset = `EXVAG_OFF_UINT + {1'b0, prio[3:0], 4'h0};
        end
        else
        begin
            cause_offset = `EXVAG_OFF_UINT_MIN;
        end
    endfunction

    // Causes that may vector through the guest base; mode-switching ones never do.
    always_comb
    begin
        case (req.cause)
            exvag_pkg::CAUSE_RESET,
            exvag_pkg::CAUSE_HV_TRAP,
            exvag_pkg::CAUSE_BACKGROUND,
            exvag_pkg::CAUSE_NONMASKABLE: guest_ok = 1'b0;
            exvag_pkg::CAUSE_SYSTEM_ERROR_EXC:      guest_ok = st_ff.guest_routing_config[`EXVAG_CFG_SYSTEM_ERROR_EXC_GUEST];
            exvag_pkg::CAUSE_MEM_PROTECT: guest_ok = st_ff.guest_routing_config[`EXVAG_CFG_MEMPROT_GUEST];
            default:                      guest_ok = 1'b1;
        endcase
    end

    // Base selection uses the post-acknowledge mode and select bits carried by the request.
    assign is_uint   = req.cause == exvag_pkg::CAUSE_USER_INTR;
    assign use_guest = req.guest_mode_flag && guest_ok;
    always_comb
    begin
        if (req.cause == exvag_pkg::CAUSE_RESET)
        begin
            sel_base = st_ff.reset_base_reg;
        end
        else if (use_guest)
        begin
            sel_base = st_ff.guest_exc_base_reg;
        end
        else if (req.base_select_bit)
        begin
            sel_base = st_ff.host_exc_base_reg;
        end
        else
        begin
            sel_base = st_ff.reset_base_reg;
        end
    end

    // Direct vector sum; the reduction bit comes from whichever base was chosen.
    assign sel_intr_offset_reduce_bit = sel_base[`EXVAG_BASE_INTR_OFFSET_REDUCE_BIT_BIT];
    assign sel_off  = cause_offset(req.cause, req.priority_level, sel_intr_offset_reduce_bit);
    assign new_addr = (sel_base & `EXVAG_BASE_MASK) + {23'h0, sel_off};

    // Next-state logic for the vector output and the register slave.
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.vec_valid = req_valid;
        if (req_valid)
        begin
            nxt_st.vec_addr  = new_addr;
            // Table lookup itself lives outside; only the choice is flagged here.
            nxt_st.vec_table = is_uint && st_ff.guest_routing_config[`EXVAG_CFG_TABLE_EN]
                               && !sel_base[`EXVAG_BASE_DV_BIT];
        end
        if (st_ff.bvalid && bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (awvalid && awready)
        begin
            nxt_st.aw_got  = 1'b1;
            nxt_st.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            nxt_st.w_got  = 1'b1;
            nxt_st.w_data = wdata;
            nxt_st.w_strb = wstrb;
        end
        // Write commits once both halves are held and no response is pending.
        if (nxt_st.aw_got && nxt_st.w_got && !st_ff.bvalid)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = `EXVAG_RESP_OKAY;
            case (reg_index(nxt_st.aw_addr))
                3'h0: nxt_st.reset_base_reg = merge(st_ff.reset_base_reg, nxt_st.w_data, nxt_st.w_strb)
                                              & `EXVAG_BASE_WMASK;
                3'h1: nxt_st.host_exc_base_reg = merge(st_ff.host_exc_base_reg, nxt_st.w_data, nxt_st.w_strb)
                                                 & `EXVAG_BASE_WMASK;
                3'h2: nxt_st.guest_exc_base_reg = merge(st_ff.guest_exc_base_reg, nxt_st.w_data, nxt_st.w_strb)
                                                  & `EXVAG_BASE_WMASK;
                3'h3:
                begin
                    if (nxt_st.w_strb[0])
                    begin
                        nxt_st.guest_routing_config = nxt_st.w_data[2:0];
                    end
                end
                3'h4: nxt_st.bresp = `EXVAG_RESP_OKAY;
                default: nxt_st.bresp = `EXVAG_RESP_SLVERR;
            endcase
        end
        if (st_ff.rvalid && rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        // Read data is captured when the address is taken and held until rready.
        if (arvalid && arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = `EXVAG_RESP_OKAY;
            case (reg_index(araddr))
                3'h0:    nxt_st.rdata = st_ff.reset_base_reg;
                3'h1:    nxt_st.rdata = st_ff.host_exc_base_reg;
                3'h2:    nxt_st.rdata = st_ff.guest_exc_base_reg;
                3'h3:    nxt_st.rdata = {29'h0, st_ff.guest_routing_config};
                3'h4:    nxt_st.rdata = st_ff.vec_addr;
                default:
                begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = `EXVAG_RESP_SLVERR;
                end
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff                      <= '0;
            st_ff.reset_base_reg       <= `EXVAG_RST_BASE;
            st_ff.host_exc_base_reg    <= `EXVAG_RST_BASE;
            st_ff.guest_exc_base_reg   <= `EXVAG_RST_BASE;
            st_ff.guest_routing_config <= `EXVAG_RST_CONFIG;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Handshakes are combinational; one write and one read outstanding at most.
    assign awready   = !st_ff.aw_got && !st_ff.bvalid;
    assign wready    = !st_ff.w_got && !st_ff.bvalid;
    assign arready   = !st_ff.rvalid;
    assign bvalid    = st_ff.bvalid;
    assign bresp     = st_ff.bresp;
    assign rvalid    = st_ff.rvalid;
    assign rdata     = st_ff.rdata;
    assign rresp     = st_ff.rresp;
    assign vec_valid = st_ff.vec_valid;
    assign vec_addr  = st_ff.vec_addr;
    assign vec_table = st_ff.vec_table;

    // Reset vectors through the reset base at offset zero.
    AST_RESET_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && req.cause == exvag_pkg::CAUSE_RESET
        |=> vec_valid && vec_addr == ($past(st_ff.reset_base_reg) & `EXVAG_BASE_MASK))
        else $error("reset vector not at reset base");

    // Host exception with select one uses the host base.
    AST_HOST_SEL1: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && !req.guest_mode_flag && req.base_select_bit && req.cause == exvag_pkg::CAUSE_FE_TRAP
        |=> vec_addr == ($past(st_ff.host_exc_base_reg) & `EXVAG_BASE_MASK) + 32'h0000_0030)
        else $error("host base not used with select one");

    // Host exception with select zero uses the reset base.
    AST_HOST_SEL0: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && !req.guest_mode_flag && !req.base_select_bit && req.cause == exvag_pkg::CAUSE_PRIVILEGE
        |=> vec_addr == ($past(st_ff.reset_base_reg) & `EXVAG_BASE_MASK) + 32'h0000_00A0)
        else $error("reset base not used with select zero");

    // Guest exception uses the guest base whatever the select bit says.
    AST_GUEST_BASE: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && req.guest_mode_flag && req.cause == exvag_pkg::CAUSE_MISALIGN
        |=> vec_addr == ($past(st_ff.guest_exc_base_reg) & `EXVAG_BASE_MASK) + 32'h0000_00C0)
        else $error("guest base not used in guest mode");

    // Mode-switching causes other than reset in guest mode still go through the host selection.
    AST_NO_GUEST_NMI: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && req.guest_mode_flag && req.cause == exvag_pkg::CAUSE_NONMASKABLE
        |=> vec_addr == ($past(req.base_select_bit) ? ($past(st_ff.host_exc_base_reg) & `EXVAG_BASE_MASK)
                         : ($past(st_ff.reset_base_reg) & `EXVAG_BASE_MASK)) + 32'h0000_00E0)
        else $error("nonmaskable vectored through guest base");

    // Unrouted system error in guest mode falls back to the host selection.
    AST_SYSTEM_ERROR_EXC_ROUTE: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && req.guest_mode_flag && req.cause == exvag_pkg::CAUSE_SYSTEM_ERROR_EXC
        && !st_ff.guest_routing_config[`EXVAG_CFG_SYSTEM_ERROR_EXC_GUEST] && req.base_select_bit
        |=> vec_addr == ($past(st_ff.host_exc_base_reg) & `EXVAG_BASE_MASK) + 32'h0000_0010)
        else $error("unrouted system error used guest base");

    // Reduction bit set collapses every user interrupt to offset 0x100.
    AST_REDUCE: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && is_uint && sel_intr_offset_reduce_bit
        |=> vec_addr == ($past(sel_base) & `EXVAG_BASE_MASK) + 32'h0000_0100)
        else $error("reduced user interrupt offset wrong");

    // Middle priorities step by 0x10 from 0x100.
    AST_PRIO_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && is_uint && !sel_intr_offset_reduce_bit && req.priority_level == 8'h0E
        |=> vec_addr == ($past(sel_base) & `EXVAG_BASE_MASK) + 32'h0000_01E0)
        else $error("priority 14 offset wrong");

    // Priority 15 and every lower level share offset 0x1F0.
    AST_PRIO_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && is_uint && !sel_intr_offset_reduce_bit && req.priority_level >= 8'h0F
        |=> vec_addr == ($past(sel_base) & `EXVAG_BASE_MASK) + 32'h0000_01F0)
        else $error("low priority offset not 0x1F0");

    // Each request gives exactly one result pulse one cycle later.
    AST_ONE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid ##1 !req_valid |=> !vec_valid)
        else $error("vector valid outlived its request");

    // Every taken request is answered on the very next cycle.
    AST_VEC_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid
        |=> vec_valid)
        else $error("vector valid missing after request");

    // Priority zero with the reduction bit clear sits at offset 0x100.
    AST_PRIO_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && is_uint && !sel_intr_offset_reduce_bit && req.priority_level == 8'h00
        |=> vec_addr == ($past(sel_base) & `EXVAG_BASE_MASK) + 32'h0000_0100)
        else $error("priority 0 offset wrong");

    // The masked base has its low nine bits clear, so they show the fixed cause offset.
    AST_FIXED_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && !is_uint
        |=> vec_addr[8:0] == {$past(req.cause), 4'h0})
        else $error("fixed cause offset wrong");

    // Only user interrupts may be handed to the table method.
    AST_TABLE_UINT: assert property (@(posedge aclk) disable iff (!aresetn)
        req_valid && !is_uint
        |=> !vec_table)
        else $error("table method flagged for a non-interrupt cause");

endmodule

// [exvag_ack_model.sv]
`timescale 1ns/1ns
module exvag_ack_model (
    // Clock, reset and pacing.
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             slow,
    // Acknowledged exception toward the vector generator.
    output exvag_pkg::exvag_req_s req,
    output logic                  req_valid
);
    exvag_pkg::exvag_req_s pend_q[$];

    // Queue one acknowledged exception; its status bits are already post-update.
    task automatic post(input exvag_pkg::exvag_req_s r);
        pend_q.push_back(r);
    endtask

    // Issue back to back, or with idle gaps when slow.
    // The idle payload is inverted so that stale data never looks like a request.
    always @(posedge aclk)
    begin
        if (!aresetn)
            req_valid <= 1'b0;
        else if (pend_q.size() > 0 && !(slow && req_valid))
        begin
            req_valid <= 1'b1;
            req       <= pend_q.pop_front();
        end
        else
        begin
            req_valid <= 1'b0;
            req       <= exvag_pkg::exvag_req_s'(~req);
        end
    end

    // Quiet outputs at time zero.
    initial
    begin
        req_valid = 1'b0;
        req       = '0;
    end
endmodule

// [test_exception_vector_address_gen.sv]
`timescale 1ns/1ns
`include "exvag_regs.svh"
module test_exception_vector_address_gen;
    logic                  aclk, aresetn, slow, req_valid, vec_valid, vec_table, prev_req;
    logic                  awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0]           vec_addr, awaddr, wdata, araddr, rdata, last_m;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    logic [2:0]            cfg_m;
    logic [31:0]           regs_m [3];
    logic [32:0]           exp_q[$];
    exvag_pkg::exvag_req_s req;
    int                    miscompares, total_checks, seed;

    exvag_ack_model i_ack (.aclk(aclk), .aresetn(aresetn), .slow(slow), .req(req), .req_valid(req_valid));

    exvag_vector_gen i_dut (.aclk(aclk), .aresetn(aresetn), .req_valid(req_valid), .req(req),
        .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_table(vec_table), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // Free-running 100 MHz clock.
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Counts every comparison and reports a difference at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single exit point for the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Write with address and data offered together; each is released once taken.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge aclk);
        n = 0;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && n < 100);
        check({31'h0, bvalid}, 32'h1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    // Read one word; the answer is taken at the edge where rvalid is seen.
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && n < 100);
        check({31'h0, rvalid}, 32'h1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Byte-lane merge into a base register mirror; unused bits read zero.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++)
            if (s[i])
                old[8*i +: 8] = d[8*i +: 8];
        return old & `EXVAG_BASE_WMASK;
    endfunction

    // Reference handler address, table flag in the top bit.
    function automatic logic [32:0] exp_vec(input exvag_pkg::exvag_req_s r);
        logic [31:0] base;
        logic [8:0]  off;
        int          c;
        int          p;
        c = int'(r.cause);
        p = int'(r.priority_level);
        if (c == 0)
            base = regs_m[0];
        else if (r.guest_mode_flag && !(c == 2 || c == 13 || c == 14) && !(c == 1 && !cfg_m[0])
                 && !(c == 9 && !cfg_m[1]))
            base = regs_m[2];
        else if (r.base_select_bit)
            base = regs_m[1];
        else
            base = regs_m[0];
        if (c < 16)
            off = 9'(c * 16);
        else if (base[0] || p == 0)
            off = 9'h100;
        else if (p <= 14)
            off = 9'(256 + 16 * p);
        else
            off = 9'h1F0;
        return {c == 16 && cfg_m[2] && !base[1], (base & 32'hFFFF_FE00) + {23'h0, off}};
    endfunction

    // Hand one request to the partner with random post-acknowledge status bits.
    task automatic send(input int c, input int p);
        exvag_pkg::exvag_req_s r;
        r.cause           = exvag_pkg::exvag_cause_e'(c);
        r.priority_level  = p[7:0];
        r.guest_mode_flag = 1'($random(seed));
        r.base_select_bit = 1'($random(seed));
        exp_q.push_back(exp_vec(r));
        i_ack.post(r);
    endtask

    // Every handler address must follow its request by exactly one cycle.
    always @(posedge aclk)
    begin
        if (aresetn && vec_valid === 1'b1)
        begin
            check({31'h0, prev_req && exp_q.size() > 0}, 32'h1);
            if (exp_q.size() > 0)
            begin
                check(vec_addr, exp_q[0][31:0]);
                check({31'h0, vec_table}, {31'h0, exp_q[0][32]});
                last_m = exp_q[0][31:0];
                void'(exp_q.pop_front());
            end
        end
        prev_req = req_valid;
    end

    // Hang guard sized well above the expected run of about five hundred cycles.
    initial
    begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        stop_test();
    end

    // Main sequence: reset values, bus refusals, then rounds of vectors.
    initial
    begin
        logic [31:0] d;
        logic [3:0]  s;
        logic [1:0]  rs;
        int          n;
        seed = 53;
        {aresetn, slow, awvalid, wvalid, bready, arvalid, rready, prev_req} = '0;
        {awaddr, wdata, araddr, last_m} = '0;
        wstrb = 4'h0;
        cfg_m = 3'h0;
        regs_m = '{3{32'h0}};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            axi_read(32'(4 * i), d, rs);
            check(d, 32'h0);
            check({30'h0, rs}, {30'h0, `EXVAG_RESP_OKAY});
        end
        axi_write(32'h14, $random(seed), 4'hF, `EXVAG_RESP_SLVERR);
        axi_write(32'h10, $random(seed), 4'hF, `EXVAG_RESP_OKAY);
        axi_read(32'h8000_0000, d, rs);
        check(d, 32'h0);
        check({30'h0, rs}, {30'h0, `EXVAG_RESP_SLVERR});
        for (int rd = 0; rd < 6; rd++)
        begin
            slow <= rd[0];
            for (int i = 0; i < 4; i++)
            begin
                d = $random(seed);
                s = (rd == 0) ? 4'hF : 4'($random(seed));
                axi_write(32'(4 * i), d, s, `EXVAG_RESP_OKAY);
                if (i < 3)
                    regs_m[i] = merge(regs_m[i], d, s);
                else if (s[0])
                    cfg_m = d[2:0];
            end
            for (int i = 0; i < 4; i++)
            begin
                axi_read(32'(4 * i), d, rs);
                check(d, (i < 3) ? regs_m[i] : {29'h0, cfg_m});
            end
            for (int c = 0; c < 16; c++)
                send(c, $random(seed));
            for (int p = 0; p < 18; p++)
                send(16, (p == 17) ? 255 : p);
            n = 0;
            while (exp_q.size() > 0 && n < 200)
            begin
                @(posedge aclk);
                n++;
            end
            check(32'(exp_q.size()), 32'h0);
            axi_read(32'h10, d, rs);
            check(d, last_m);
        end
        stop_test();
    end
endmodule
